//--- hdl/pcrs_pkg.sv
// Constants, register map and operation codes of the program counter block.
package pcrs_pkg;
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STACK_DEPTH = 31;
    localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
    localparam logic [SP_W-1:0] SP_ONE = 5'h01;
    localparam logic [SP_W-1:0] SP_LAST_FREE = 5'h1E;
    localparam logic [SP_W-1:0] SP_TOP = 5'h1F;
    localparam logic [PC_W-1:0] PC_RESET = 21'h0_0000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;
    localparam logic [PC_W-1:0] PC_ALIGN = 21'h1F_FFFE;
    localparam logic [7:0] BYTE_ALIGN = 8'hFE;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_PC_LOW = 8'h00;
    localparam logic [7:0] OFS_HIGH_LATCH = 8'h04;
    localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
    localparam logic [7:0] OFS_STK_PTR = 8'h0C;
    localparam logic [7:0] OFS_TOP_LOW = 8'h10;
    localparam logic [7:0] OFS_TOP_HIGH = 8'h14;
    localparam logic [7:0] OFS_TOP_UPPER = 8'h18;
    localparam logic [7:0] OFS_CONFIG = 8'h1C;
    // Field positions of the stack pointer and config registers.
    localparam int FULL_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam int CFG_STVR_BIT = 0;
    localparam logic ERR_RESET_EN_RST = 1'b1;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // Operations requested by the execution logic, one per cycle.
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SEQ = 4'h1,
        OP_CALL = 4'h2,
        OP_RELATIVE_CALL_OP = 4'h3,
        OP_GOTO = 4'h4,
        OP_RETURN = 4'h5,
        OP_RETURN_WITH_LITERAL_OP = 4'h6,
        OP_RETURN_FROM_INTERRUPT_OP = 4'h7,
        OP_PUSH = 4'h8,
        OP_POP = 4'h9,
        OP_INTACK = 4'hA
    } pcrs_op_t;

    // True for operations that push onto the return stack.
    function automatic logic pcrs_is_push(input pcrs_op_t op);
        return op inside {OP_CALL, OP_RELATIVE_CALL_OP, OP_INTACK, OP_PUSH};
    endfunction

    // True for operations that return through the stack into the counter.
    function automatic logic pcrs_is_ret(input pcrs_op_t op);
        return op inside {OP_RETURN, OP_RETURN_WITH_LITERAL_OP, OP_RETURN_FROM_INTERRUPT_OP};
    endfunction
endpackage

//--- hdl/pcrs_core.sv
// Program counter, latches, return address stack and fast shadow registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Counter is 21 bits in three bytes; only low byte is accessible.
// - Middle byte holds bits 15..8, loaded only through the high latch.
// - Upper byte holds bits 20..16, loaded only through the upper latch.
// - Writing the low byte also copies both latches into the counter.
// - Reading the low byte copies counter upper bytes into both latches.
// - Counter bit 0 stays zero; sequential fetch adds two.
// - Calls, gotos and branches load the counter without using latches.
// - Stack holds 31 addresses; calls and interrupts push, returns pop.
// - Calls and returns never change the two latches.
// - Own 31 by 21 stack memory with a readable writable 5-bit pointer.
// - Push increments pointer first, then writes the counter there.
// - Pop loads counter from the pointed entry, then decrements pointer.
// - Reset clears pointer to zero; zero is the empty state only.
// - Three top registers show and overwrite the entry at the pointer.
// - Pointer register: full bit 7, underflow 6, zero 5, pointer 4..0.
// - Full flag sets after 31 pushes and stays until cleared or power-on.
// - Reset on: 31st push stores pc+2, sets full, resets, pointer to 0.
// - With error reset off, pointer stops at 31 and entry 31 is kept.
// - Pop at zero loads zero, sets sticky underflow, pointer stays zero.
// - With error reset on, the 31st push or an underflow also resets the device; a push at pointer 31 only sets full.
// - Push op stores the counter; pop op only decrements the pointer.
// - Interrupt or fast call fills the shadow; fast return restores it.
module pcrs_core
    import pcrs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pcrs_op_t op_code,
    input wire logic op_fast,
    input wire logic [PC_W-1:0] op_target,
    input wire logic [7:0] status_in,
    input wire logic [7:0] working_register_in,
    input wire logic [3:0] bank_select_register_in,
    output logic [PC_W-1:0] pc_out,
    output logic shadow_restore,
    output logic [7:0] shadow_status,
    output logic [7:0] shadow_working,
    output logic [3:0] shadow_bank,
    output logic stack_reset_req,
    output logic stack_full_flag,
    output logic stack_underflow_flag
);
    logic [PC_W-1:0] pc_q, pc_d;
    logic [7:0] pc_high_latch_q, pc_high_latch_d;
    logic [4:0] pc_upper_latch_q, pc_upper_latch_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic full_q, full_d, unf_q, unf_d;
    logic err_en_q, err_en_d;
    logic [7:0] sh_st_q, sh_st_d, sh_w_q, sh_w_d;
    logic [3:0] sh_b_q, sh_b_d;
    logic rst_req_q, rst_req_d, restore_q, restore_d;
    logic [31:0] rdata_q, rdata_d;
    logic [PC_W-1:0] stack_mem [1:STACK_DEPTH];
    logic mem_we;
    logic [SP_W-1:0] mem_addr;
    logic [PC_W-1:0] mem_wdata;
    logic [PC_W-1:0] top_entry;
    logic access, wr_acc, rd_acc, mapped, do_push, do_ret;

    // APB decode; the slave never waits and flags unmapped offsets.
    assign access = psel && penable;
    assign wr_acc = access && pwrite && mapped;
    assign rd_acc = access && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = rdata_q;
    assign do_push = pcrs_is_push(op_code);
    assign do_ret = pcrs_is_ret(op_code);
    assign top_entry = (sp_q == SP_EMPTY) ? PC_RESET : stack_mem[sp_q];
    assign pc_out = pc_q;
    assign shadow_restore = restore_q;
    assign shadow_status = sh_st_q;
    assign shadow_working = sh_w_q;
    assign shadow_bank = sh_b_q;
    assign stack_reset_req = rst_req_q;
    assign stack_full_flag = full_q;
    assign stack_underflow_flag = unf_q;

    // Offset decode, used to qualify bus writes and reads and for the error answer.
    always_comb begin
        unique case (paddr)
            OFS_PC_LOW, OFS_HIGH_LATCH, OFS_UPPER_LATCH, OFS_STK_PTR,
            OFS_TOP_LOW, OFS_TOP_HIGH, OFS_TOP_UPPER, OFS_CONFIG: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Read data is prepared in the setup cycle and shown in the access cycle.
    always_comb begin
        rdata_d = rdata_q;
        if (psel && !penable && !pwrite) begin
            rdata_d = RD_ZERO;
            unique case (paddr)
                OFS_PC_LOW: rdata_d[7:0] = pc_q[7:0];
                OFS_HIGH_LATCH: rdata_d[7:0] = pc_high_latch_q;
                OFS_UPPER_LATCH: rdata_d[4:0] = pc_upper_latch_q;
                OFS_STK_PTR: begin
                    rdata_d[7:0] = {full_q, unf_q, 1'b0, sp_q};
                end
                OFS_TOP_LOW: rdata_d[7:0] = top_entry[7:0];
                OFS_TOP_HIGH: rdata_d[7:0] = top_entry[15:8];
                OFS_TOP_UPPER: rdata_d[4:0] = top_entry[20:16];
                OFS_CONFIG: rdata_d[CFG_STVR_BIT] = err_en_q;
                default: rdata_d = RD_ZERO;
            endcase
        end
    end

    // Next state of counter, latches, stack and flags; bus first, core last.
    always_comb begin
        pc_d = pc_q;
        pc_high_latch_d = pc_high_latch_q;
        pc_upper_latch_d = pc_upper_latch_q;
        sp_d = sp_q;
        full_d = full_q;
        unf_d = unf_q;
        err_en_d = err_en_q;
        sh_st_d = sh_st_q;
        sh_w_d = sh_w_q;
        sh_b_d = sh_b_q;
        rst_req_d = 1'b0;
        restore_d = 1'b0;
        mem_we = 1'b0;
        mem_addr = sp_q;
        mem_wdata = top_entry;
        // Software accesses; the pointer takes the new value at once.
        if (wr_acc) begin
            unique case (paddr)
                OFS_PC_LOW: begin
                    pc_d = {pc_upper_latch_q, pc_high_latch_q,
                            pwdata[7:0] & BYTE_ALIGN};
                end
                OFS_HIGH_LATCH: pc_high_latch_d = pwdata[7:0];
                OFS_UPPER_LATCH: pc_upper_latch_d = pwdata[4:0];
                OFS_STK_PTR: begin
                    sp_d = pwdata[SP_W-1:0];
                    full_d = full_q && pwdata[FULL_BIT];
                    unf_d = unf_q && pwdata[UNF_BIT];
                end
                OFS_TOP_LOW: begin
                    mem_we = (sp_q != SP_EMPTY);
                    mem_wdata[7:0] = pwdata[7:0];
                end
                OFS_TOP_HIGH: begin
                    mem_we = (sp_q != SP_EMPTY);
                    mem_wdata[15:8] = pwdata[7:0];
                end
                OFS_TOP_UPPER: begin
                    mem_we = (sp_q != SP_EMPTY);
                    mem_wdata[20:16] = pwdata[4:0];
                end
                OFS_CONFIG: err_en_d = pwdata[CFG_STVR_BIT];
                default: begin
                end
            endcase
        end
        if (rd_acc && paddr == OFS_PC_LOW) begin
            pc_high_latch_d = pc_q[15:8];
            pc_upper_latch_d = pc_q[20:16];
        end
        // Core operations; no branch below touches the latches.
        if (op_code == OP_SEQ) begin
            pc_d = (pc_q + PC_STEP) & PC_ALIGN;
        end
        if (op_code inside {OP_CALL, OP_RELATIVE_CALL_OP, OP_GOTO, OP_INTACK}) begin
            pc_d = op_target & PC_ALIGN;
        end
        if (do_push) begin
            if (sp_q == SP_TOP) begin
                full_d = 1'b1;
            end else begin
                sp_d = sp_q + SP_ONE;
                mem_addr = sp_d;
                mem_we = 1'b1;
                mem_wdata = pc_q;
                if (sp_q == SP_LAST_FREE) begin
                    full_d = 1'b1;
                    if (err_en_q) begin
                        mem_wdata = pc_q + PC_STEP;
                        sp_d = SP_EMPTY;
                        pc_d = PC_RESET;
                        rst_req_d = 1'b1;
                    end
                end
            end
        end
        if (do_ret || op_code == OP_POP) begin
            if (sp_q == SP_EMPTY) begin
                unf_d = 1'b1;
                if (do_ret) begin
                    pc_d = PC_RESET;
                end
                if (err_en_q) begin
                    pc_d = PC_RESET;
                    rst_req_d = 1'b1;
                end
            end else begin
                if (do_ret) begin
                    pc_d = top_entry & PC_ALIGN;
                end
                sp_d = sp_q - SP_ONE;
            end
        end
        // Shadow registers for fast interrupt entry and fast returns.
        if (op_code == OP_INTACK || (op_code == OP_CALL && op_fast)) begin
            sh_st_d = status_in;
            sh_w_d = working_register_in;
            sh_b_d = bank_select_register_in;
        end
        if (op_fast && op_code inside {OP_RETURN, OP_RETURN_FROM_INTERRUPT_OP}) begin
            restore_d = 1'b1;
        end
    end

    // Control and status registers; power-on reset clears the sticky flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= PC_RESET;
            pc_high_latch_q <= 8'h00;
            pc_upper_latch_q <= 5'h00;
            sp_q <= SP_EMPTY;
            full_q <= 1'b0;
            unf_q <= 1'b0;
            err_en_q <= ERR_RESET_EN_RST;
            sh_st_q <= 8'h00;
            sh_w_q <= 8'h00;
            sh_b_q <= 4'h0;
            rst_req_q <= 1'b0;
            restore_q <= 1'b0;
            rdata_q <= RD_ZERO;
        end else begin
            pc_q <= pc_d;
            pc_high_latch_q <= pc_high_latch_d;
            pc_upper_latch_q <= pc_upper_latch_d;
            sp_q <= sp_d;
            full_q <= full_d;
            unf_q <= unf_d;
            err_en_q <= err_en_d;
            sh_st_q <= sh_st_d;
            sh_w_q <= sh_w_d;
            sh_b_q <= sh_b_d;
            rst_req_q <= rst_req_d;
            restore_q <= restore_d;
            rdata_q <= rdata_d;
        end
    end

    // Stack storage; entry zero does not exist.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 1; i <= STACK_DEPTH; i++) begin
                stack_mem[i] <= PC_RESET;
            end
        end else if (mem_we && mem_addr != SP_EMPTY) begin
            stack_mem[mem_addr] <= mem_wdata;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_push_ok;
        pcrs_is_push(op_code) && sp_q < SP_LAST_FREE;
    endsequence
    sequence s_err_push;
        pcrs_is_push(op_code) && sp_q == SP_LAST_FREE && err_en_q;
    endsequence

    chk_pc_lsb_zero: assert property (pc_q[0] == 1'b0)
        else $error("Counter bit zero is set.");
    chk_seq_step: assert property (op_code == OP_SEQ |=>
        pc_q == (($past(pc_q) + PC_STEP) & PC_ALIGN))
        else $error("Sequential fetch did not add two.");
    chk_low_write: assert property (wr_acc &&
        paddr == OFS_PC_LOW && op_code == OP_NONE |=> pc_q[20:8] ==
        {$past(pc_upper_latch_q), $past(pc_high_latch_q)})
        else $error("Low byte write did not load the latches.");
    chk_low_read: assert property (rd_acc &&
        paddr == OFS_PC_LOW |=> pc_high_latch_q == $past(pc_q[15:8]))
        else $error("Low byte read did not fill the high latch.");
    chk_latch_keep: assert property ((do_push || do_ret) &&
        !access |=> $stable(pc_high_latch_q) && $stable(pc_upper_latch_q))
        else $error("Call or return changed a latch.");
    chk_push_order: assert property (s_push_ok |=>
        sp_q == $past(sp_q) + SP_ONE && stack_mem[sp_q] == $past(pc_q))
        else $error("Push did not store the counter above the pointer.");
    chk_under_pop: assert property (do_ret && sp_q == SP_EMPTY |=>
        pc_q == PC_RESET && unf_q && sp_q == SP_EMPTY)
        else $error("Underflow pop gave a wrong result.");
    chk_full_hold: assert property (do_push && sp_q == SP_TOP &&
        !err_en_q && !access |=> sp_q == SP_TOP && full_q &&
        $stable(stack_mem[SP_TOP]))
        else $error("Push past full moved the pointer.");
    chk_full_reset: assert property (s_err_push |=>
        sp_q == SP_EMPTY && full_q && stack_reset_req ##1 !stack_reset_req)
        else $error("Stack error reset sequence is wrong.");
    chk_fast_restore: assert property (op_fast &&
        op_code == OP_RETURN_FROM_INTERRUPT_OP |=> shadow_restore)
        else $error("Fast return did not restore the shadow.");
endmodule
`default_nettype wire

//--- dv/pcrs_exec_model.sv
// Model of the core execution logic that issues counter and stack requests.
`timescale 1ns/1ps
`default_nettype none
module pcrs_exec_model
    import pcrs_pkg::*;
(
    input wire logic pclk,
    output var pcrs_op_t op_code,
    output logic op_fast,
    output logic [PC_W-1:0] op_target,
    output logic [7:0] status_in,
    output logic [7:0] working_register_in,
    output logic [3:0] bank_select_register_in
);
    // The core starts idle with every qualifier at a defined level.
    initial begin
        op_code = OP_NONE;
        op_fast = 1'b0;
        op_target = PC_RESET;
        {status_in, working_register_in, bank_select_register_in} = '0;
    end

    // Issues a request n times, one edge each, with an idle cycle after it.
    // Outside a request the target and register inputs show the inverse of their last value; op_fast keeps it.
    task automatic issue(input pcrs_op_t op, input logic [PC_W-1:0] tgt,
                         input logic fast, input logic [19:0] regs,
                         input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            op_code <= op;
            op_fast <= fast;
            op_target <= tgt;
            {status_in, working_register_in, bank_select_register_in} <= regs;
            @(posedge pclk);
            op_code <= OP_NONE;
            op_target <= ~tgt;
            {status_in, working_register_in, bank_select_register_in} <= ~regs;
        end
        #1;
    endtask
endmodule
`default_nettype wire

//--- dv/program_counter_return_stack_tb.sv
// Self-checking testbench of the program counter and return stack block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp); \
        end \
    end
module program_counter_return_stack_tb;
    import pcrs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic pready, pslverr, errv, op_fast, shadow_restore, stack_reset_req;
    logic stack_full_flag, stack_underflow_flag;
    pcrs_op_t op_code;
    logic [PC_W-1:0] op_target, pc_out;
    logic [7:0] status_in, working_register_in, shadow_status, shadow_working;
    logic [3:0] bank_select_register_in, shadow_bank;
    int checks = 0;
    int n_mismatch = 0;

    pcrs_core pcrs_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_code(op_code), .op_fast(op_fast), .op_target(op_target),
        .status_in(status_in), .working_register_in(working_register_in),
        .bank_select_register_in(bank_select_register_in), .pc_out(pc_out),
        .shadow_restore(shadow_restore), .shadow_status(shadow_status),
        .shadow_working(shadow_working), .shadow_bank(shadow_bank),
        .stack_reset_req(stack_reset_req), .stack_full_flag(stack_full_flag),
        .stack_underflow_flag(stack_underflow_flag));
    pcrs_exec_model pcrs_exec_model_i (.pclk(pclk), .op_code(op_code),
        .op_fast(op_fast), .op_target(op_target), .status_in(status_in),
        .working_register_in(working_register_in),
        .bank_select_register_in(bank_select_register_in));

    // Clock at 100 MHz.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end else begin
            rdv = prdata;
            errv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // Let the edge's register updates settle before callers look.
            #1;
        end
    endtask

    // Reads a byte register and compares it with the expected byte.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdv, {24'h00_0000, e}, "register read")
    endtask

    // Issues a plain core request n times.
    task automatic go(input pcrs_op_t o, input logic [PC_W-1:0] t, input int n);
        pcrs_exec_model_i.issue(o, t, 1'b0, 20'h0_0000, n);
    endtask

    // Reset values, the empty top entry and an unmapped access.
    task automatic t_reset();
        `CHK(pc_out, PC_RESET, "pc reset")
        rd_chk(OFS_STK_PTR, 8'h00);
        rd_chk(OFS_CONFIG, 8'h01);
        rd_chk(OFS_TOP_LOW, 8'h00);
        rd_chk(8'h20, 8'h00);
        `CHK(errv, 1'b1, "unmapped error")
        $display("t_reset done");
    endtask

    // Latch transfers on low byte write and read; direct loads skip them.
    task automatic t_latch();
        apb(1'b1, OFS_HIGH_LATCH, 32'h0000_0012);
        apb(1'b1, OFS_UPPER_LATCH, 32'h0000_0005);
        `CHK(pc_out, PC_RESET, "latch alone")
        apb(1'b1, OFS_PC_LOW, 32'h0000_0035);
        `CHK(pc_out, 21'h05_1234, "low write")
        go(OP_GOTO, 21'h0A_BCDF, 1);
        `CHK(pc_out, 21'h0A_BCDE, "goto")
        rd_chk(OFS_HIGH_LATCH, 8'h12);
        rd_chk(OFS_PC_LOW, 8'hDE);
        rd_chk(OFS_HIGH_LATCH, 8'hBC);
        rd_chk(OFS_UPPER_LATCH, 8'h0A);
        go(OP_SEQ, 21'h00_0000, 1);
        `CHK(pc_out, 21'h0A_BCE0, "seq")
        $display("t_latch done");
    endtask

    // Each call and interrupt push, then each return kind, with the top entry inspected.
    task automatic t_call();
        pcrs_op_t ps[3] = '{OP_CALL, OP_RELATIVE_CALL_OP, OP_INTACK};
        pcrs_op_t rt[3] = '{OP_RETURN, OP_RETURN_WITH_LITERAL_OP, OP_RETURN_FROM_INTERRUPT_OP};
        logic [20:0] tg[4] = '{21'h0A_BCE0, 21'h00_1000, 21'h00_2000,
                               21'h00_0008};
        apb(1'b1, OFS_HIGH_LATCH, 32'h0000_0077);
        apb(1'b1, OFS_UPPER_LATCH, 32'h0000_001B);
        for (int i = 0; i < 3; i++) begin
            go(ps[i], tg[i+1], 1);
            `CHK(pc_out, tg[i+1], "push target")
            rd_chk(OFS_STK_PTR, 8'(i + 1));
            rd_chk(OFS_TOP_LOW, tg[i][7:0]);
            rd_chk(OFS_TOP_HIGH, tg[i][15:8]);
            rd_chk(OFS_TOP_UPPER, 8'(tg[i][20:16]));
        end
        for (int i = 2; i >= 0; i--) begin
            go(rt[i], 21'h00_0000, 1);
            `CHK(pc_out, tg[i], "pop value")
            rd_chk(OFS_STK_PTR, 8'(i));
        end
        rd_chk(OFS_HIGH_LATCH, 8'h77);
        rd_chk(OFS_UPPER_LATCH, 8'h1B);
        $display("t_call done");
    endtask

    // Pointer and top entry written by software, then used by a return.
    task automatic t_top();
        apb(1'b1, OFS_STK_PTR, 32'h0000_0003);
        rd_chk(OFS_STK_PTR, 8'h03);
        apb(1'b1, OFS_TOP_LOW, 32'h0000_0056);
        apb(1'b1, OFS_TOP_HIGH, 32'h0000_0034);
        apb(1'b1, OFS_TOP_UPPER, 32'h0000_0012);
        go(OP_RETURN, 21'h00_0000, 1);
        `CHK(pc_out, 21'h12_3456, "top write")
        rd_chk(OFS_STK_PTR, 8'h02);
        $display("t_top done");
    endtask

    // Fill with error reset off, push past full, clear the flag.
    task automatic t_full_off();
        apb(1'b1, OFS_CONFIG, 32'h0000_0000);
        apb(1'b1, OFS_STK_PTR, 32'h0000_0000);
        go(OP_CALL, 21'h00_0100, 30);
        rd_chk(OFS_STK_PTR, 8'h1E);
        `CHK(stack_full_flag, 1'b0, "not yet full")
        go(OP_CALL, 21'h00_0100, 1);
        rd_chk(OFS_STK_PTR, 8'h9F);
        `CHK(stack_full_flag, 1'b1, "full")
        go(OP_GOTO, 21'h00_0500, 1);
        go(OP_CALL, 21'h00_0200, 1);
        rd_chk(OFS_STK_PTR, 8'h9F);
        rd_chk(OFS_TOP_HIGH, 8'h01);
        apb(1'b1, OFS_STK_PTR, 32'h0000_003F);
        rd_chk(OFS_STK_PTR, 8'h1F);
        $display("t_full_off done");
    endtask

    // Software push and pop, then underflow with error reset off and on.
    task automatic t_unf();
        apb(1'b1, OFS_STK_PTR, 32'h0000_0000);
        go(OP_GOTO, 21'h00_0300, 1);
        go(OP_PUSH, 21'h00_0000, 1);
        rd_chk(OFS_TOP_HIGH, 8'h03);
        go(OP_POP, 21'h00_0000, 1);
        `CHK(pc_out, 21'h00_0300, "pop keeps pc")
        rd_chk(OFS_STK_PTR, 8'h00);
        go(OP_RETURN, 21'h00_0000, 1);
        `CHK(stack_reset_req, 1'b0, "no reset")
        `CHK(pc_out, PC_RESET, "underflow pc")
        rd_chk(OFS_STK_PTR, 8'h40);
        apb(1'b1, OFS_CONFIG, 32'h0000_0001);
        go(OP_RETURN, 21'h00_0000, 1);
        `CHK(stack_reset_req, 1'b1, "underflow reset")
        `CHK(stack_underflow_flag, 1'b1, "unf sticky")
        $display("t_unf done");
    endtask

    // Fill with error reset on: the last push stores pc plus two and resets.
    task automatic t_full_on();
        apb(1'b1, OFS_STK_PTR, 32'h0000_0000);
        go(OP_GOTO, 21'h00_0400, 1);
        go(OP_CALL, 21'h00_0400, 31);
        `CHK(stack_reset_req, 1'b1, "full reset")
        rd_chk(OFS_STK_PTR, 8'h80);
        apb(1'b1, OFS_STK_PTR, 32'h0000_009F);
        rd_chk(OFS_TOP_HIGH, 8'h04);
        rd_chk(OFS_TOP_LOW, 8'h02);
        // A power-on reset in mid-run clears the sticky full flag.
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK(stack_full_flag, 1'b0, "power-on clears full")
        rd_chk(OFS_STK_PTR, 8'h00);
        apb(1'b1, OFS_STK_PTR, 32'h0000_0000);
        $display("t_full_on done");
    endtask

    // Shadow load on interrupt and fast call, restore pulse on fast return.
    task automatic t_shadow();
        pcrs_exec_model_i.issue(OP_INTACK, 21'h00_0008, 1'b0, 20'hA5_3C7, 1);
        `CHK({shadow_status, shadow_working, shadow_bank}, 20'hA5_3C7,
             "intack shadow")
        pcrs_exec_model_i.issue(OP_CALL, 21'h00_0010, 1'b1, 20'h5A_C39, 1);
        pcrs_exec_model_i.issue(OP_CALL, 21'h00_0020, 1'b0, 20'h11_223, 1);
        `CHK({shadow_status, shadow_working, shadow_bank}, 20'h5A_C39,
             "fast call shadow")
        pcrs_exec_model_i.issue(OP_RETURN, 21'h00_0000, 1'b1, 20'h0_0000, 1);
        `CHK(shadow_restore, 1'b1, "fast return")
        go(OP_RETURN_FROM_INTERRUPT_OP, 21'h00_0000, 1);
        `CHK(shadow_restore, 1'b0, "plain return")
        pcrs_exec_model_i.issue(OP_RETURN_FROM_INTERRUPT_OP, 21'h00_0000, 1'b1, 20'h0_0000, 1);
        `CHK(shadow_restore, 1'b1, "fast return_from_interrupt_op")
        $display("t_shadow done");
    endtask

    // Reset for four cycles, then every scenario in turn.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_latch();
        t_call();
        t_top();
        t_full_off();
        t_unf();
        t_full_on();
        t_shadow();
        report_and_stop();
    end
endmodule
`default_nettype wire
